/* File: rtl/asc_ctrl.sv */
// Host controller driving an asynchronous 256K x 16 SRAM with error flag
// Function
// - Write starts only with strobe low, chip selected and a byte select low.
// - Write data valid 25 ns before terminating edge, held 0 ns after.
// - Write strobe stays high for every read cycle.
// - Strobe low pulse lasts at least data setup plus strobe-to-float time.
// - Address stable 35 or 45 ns before write ends.
// - Address set 0 ns before write start, kept 0 ns after end.
// - Address never moves before the terminating write edge.
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_ctrl (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             req_valid,
  input  wire asc_pkg::asc_req_t req,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic [15:0]           rsp_rdata,
  output logic                  rsp_err,
  output asc_pkg::asc_pins_t    pins,
  output logic [15:0]           data_out,
  output logic [15:0]           data_oe,
  input  wire logic [15:0]      data_in,
  input  wire logic             err_in
);

  asc_pkg::asc_state_t state_ff;
  asc_pkg::asc_state_t nxt_state;
  asc_pkg::asc_pins_t  pins_ff;
  asc_pkg::asc_pins_t  nxt_pins;
  logic [15:0]         dout_ff;
  logic [15:0]         nxt_dout;
  logic                drive_ff;
  logic                nxt_drive;
  logic                rsp_valid_ff;
  logic                nxt_rsp_valid;
  logic [15:0]         rdata_ff;
  logic [15:0]         nxt_rdata;
  logic                rerr_ff;
  logic                nxt_rerr;
  logic                cnt_load;
  logic [4:0]          cnt_value;
  logic                cnt_done;

  localparam logic [4:0] RD_CYC  = 5'(`ASC_RD_CYC);
  localparam logic [4:0] WR_CYC  = 5'(`ASC_WR_CYC);
  localparam logic [4:0] REC_CYC = 5'(`ASC_REC_CYC);
  localparam int         RD_DLY  = `ASC_RD_CYC;
  localparam int         REC_DLY = `ASC_REC_CYC;

  asc_counter u_cnt (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .load    (cnt_load),
    .value   (cnt_value),
    .done    (cnt_done)
  );

  // ========================================================================
  // Sequencer
  // Address and selects are set on the same edge as the strobe falls and kept
  // until REC_CYC cycles after it rises, so the strobe alone ends every write.
  always_comb begin
    nxt_state     = state_ff;
    nxt_pins      = pins_ff;
    nxt_dout      = dout_ff;
    nxt_drive     = drive_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rdata     = rdata_ff;
    nxt_rerr      = rerr_ff;
    cnt_load      = 1'b0;
    cnt_value     = 5'h00;
    unique case (state_ff)
      asc_pkg::ASC_IDLE: begin
        if (req_valid) begin
          nxt_pins.addr                = req.addr;
          nxt_pins.chip_select_low_n   = 1'b0;
          nxt_pins.chip_select_high    = 1'b1;
          nxt_pins.upper_byte_select_n = ~req.byte_en[1];
          nxt_pins.lower_byte_select_n = ~req.byte_en[0];
          cnt_load                     = 1'b1;
          if (req.write && (req.byte_en != 2'b00)) begin
            nxt_pins.write_strobe_n = 1'b0;
            nxt_pins.output_gate_n  = 1'b1;
            nxt_dout                = req.wdata;
            nxt_drive               = 1'b1;
            cnt_value               = WR_CYC;
            nxt_state               = asc_pkg::ASC_WR;
          end else begin
            nxt_pins.write_strobe_n = 1'b1;
            nxt_pins.output_gate_n  = 1'b0;
            nxt_drive               = 1'b0;
            cnt_value               = RD_CYC;
            nxt_state               = asc_pkg::ASC_RD;
          end
        end
      end
      asc_pkg::ASC_RD: begin
        if (cnt_done) begin
          nxt_rsp_valid          = 1'b1;
          nxt_rdata              = data_in;
          nxt_rerr               = err_in;
          nxt_pins.output_gate_n = 1'b1;
          cnt_load               = 1'b1;
          cnt_value              = REC_CYC;
          nxt_state              = asc_pkg::ASC_REC;
        end
      end
      asc_pkg::ASC_WR: begin
        if (cnt_done) begin
          // Data driven one more cycle, address kept until the next request: hold after edge is 0 ns
          nxt_pins.write_strobe_n = 1'b1;
          nxt_rsp_valid           = 1'b1;
          cnt_load                = 1'b1;
          cnt_value               = REC_CYC;
          nxt_state               = asc_pkg::ASC_REC;
        end
      end
      asc_pkg::ASC_REC: begin
        nxt_drive = 1'b0;
        if (cnt_done) begin
          nxt_pins.chip_select_low_n   = 1'b1;
          nxt_pins.chip_select_high    = 1'b0;
          nxt_pins.upper_byte_select_n = 1'b1;
          nxt_pins.lower_byte_select_n = 1'b1;
          nxt_state                    = asc_pkg::ASC_IDLE;
        end
      end
      default: begin
        nxt_state = asc_pkg::ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= asc_pkg::ASC_IDLE;
      pins_ff      <= '{addr: 18'h00000, chip_select_low_n: 1'b1, chip_select_high: 1'b0,
                        write_strobe_n: 1'b1, output_gate_n: 1'b1,
                        upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1};
      dout_ff      <= 16'h0000;
      drive_ff     <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rdata_ff     <= 16'h0000;
      rerr_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      pins_ff      <= nxt_pins;
      dout_ff      <= nxt_dout;
      drive_ff     <= nxt_drive;
      rsp_valid_ff <= nxt_rsp_valid;
      rdata_ff     <= nxt_rdata;
      rerr_ff      <= nxt_rerr;
    end
  end

  assign req_ready = (state_ff == asc_pkg::ASC_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;
  assign rsp_err   = rerr_ff;
  assign pins      = pins_ff;
  assign data_out  = dout_ff;
  assign data_oe   = {16{drive_ff}};

  // ========================================================================
  // Checks
  logic [4:0] strobe_low_ff;
  logic [4:0] nxt_strobe_low;

  // Strobe low length, saturating so a stuck strobe cannot wrap to a short count
  always_comb begin
    nxt_strobe_low = 5'h00;
    if (!pins_ff.write_strobe_n && (strobe_low_ff != 5'h1f)) begin
      nxt_strobe_low = strobe_low_ff + 5'h01;
    end else if (!pins_ff.write_strobe_n) begin
      nxt_strobe_low = strobe_low_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_low_ff <= 5'h00;
    end else begin
      strobe_low_ff <= nxt_strobe_low;
    end
  end

  a_write_needs_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pins_ff.write_strobe_n |-> (!pins_ff.chip_select_low_n && pins_ff.chip_select_high
      && !(pins_ff.upper_byte_select_n && pins_ff.lower_byte_select_n)))
    else $error("strobe low without selects");
  a_read_strobe_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pins_ff.output_gate_n |-> pins_ff.write_strobe_n)
    else $error("strobe low during read");
  a_strobe_pulse_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(pins_ff.write_strobe_n) |-> (strobe_low_ff >= WR_CYC))
    else $error("strobe pulse too short");
  a_addr_stable_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pins_ff.write_strobe_n |=> $stable(pins_ff.addr))
    else $error("address moved during write");
  a_data_held_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(pins_ff.write_strobe_n) |-> $stable(dout_ff) && drive_ff)
    else $error("write data not held at edge");
  a_sel_combo: assert property (@(posedge ref_clk) disable iff (!nrst)
    pins_ff.chip_select_low_n == !pins_ff.chip_select_high)
    else $error("chip selects disagree");
  a_read_sample: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(pins_ff.output_gate_n) |-> ##RD_DLY rsp_valid_ff)
    else $error("read answer late or early");
  a_no_drive_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pins_ff.output_gate_n |-> !drive_ff)
    else $error("host drives during read");
  a_req_back: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(rsp_valid_ff) |-> ##REC_DLY req_ready)
    else $error("recovery count wrong");

  c_read: cover property (@(posedge ref_clk) disable iff (!nrst)
    rsp_valid_ff && pins_ff.write_strobe_n && !drive_ff);
  c_write: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(pins_ff.write_strobe_n));
  c_err: cover property (@(posedge ref_clk) disable iff (!nrst) rsp_valid_ff && rerr_ff);

endmodule : asc_ctrl

/* File: rtl/asc_defines.svh */
// Timing constants and bus widths for the asynchronous SRAM host controller
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// ==========================================================================
// Bus widths
`define ASC_ADDR_W                 18
`define ASC_DATA_W                 16

// ==========================================================================
// Clock period in ps (250 MHz)
`define ASC_CLK_PS                 4000

// ==========================================================================
// Device timing in ps, slow grade figures so either grade is met
`define ASC_READ_CYCLE_PS          55000
`define ASC_ADDRESS_ACCESS_PS      55000
`define ASC_ADDRESS_CHANGE_HOLD_PS 10000
`define ASC_GATE_ACCESS_PS         25000
`define ASC_BYTE_ACCESS_PS         25000
`define ASC_WRITE_CYCLE_PS         55000
`define ASC_ADDR_TO_WR_END_PS      45000
`define ASC_ADDR_TO_WR_START_PS    0
`define ASC_ADDR_HOLD_AFTER_WR_PS  0
`define ASC_DATA_SETUP_PS          25000
`define ASC_DATA_HOLD_PS           0
`define ASC_STROBE_LOW_FLOAT_PS    20000
`define ASC_STROBE_HIGH_DRIVE_PS   10000
`define ASC_STROBE_PULSE_PS        40000
`define ASC_GATE_HIGH_FLOAT_PS     18000

// ==========================================================================
// Cycle counts, least times rounded up
`define ASC_CEIL(ps)  (((ps) + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_MAX1(n)   (((n) < 1) ? 1 : (n))
// Read sample point covers address access and gate and byte access
`define ASC_RD_CYC    `ASC_MAX1(`ASC_CEIL(`ASC_ADDRESS_ACCESS_PS))
// Strobe low: setup+float alone, which also covers pulse width and address-to-end
`define ASC_WR_CYC    `ASC_MAX1(`ASC_CEIL(`ASC_DATA_SETUP_PS + `ASC_STROBE_LOW_FLOAT_PS))
// Turnaround after a write or read before the next access
`define ASC_REC_CYC   `ASC_MAX1(`ASC_CEIL(`ASC_STROBE_HIGH_DRIVE_PS))
`define ASC_CNT_W     5

`endif

/* File: rtl/asc_pkg.sv */
// Types shared by the SRAM host controller
package asc_pkg;

  // ========================================================================
  // Pins toward the SRAM, all control pins active low except chip_select_high
  typedef struct packed {
    logic [17:0] addr;
    logic        chip_select_low_n;
    logic        chip_select_high;
    logic        write_strobe_n;
    logic        output_gate_n;
    logic        upper_byte_select_n;
    logic        lower_byte_select_n;
  } asc_pins_t;

  // ========================================================================
  // User request
  typedef struct packed {
    logic        write;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [1:0]  byte_en;
  } asc_req_t;

  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD,
    ASC_WR,
    ASC_REC
  } asc_state_t;

endpackage : asc_pkg

/* File: rtl/asc_counter.sv */
// Down counter timing one access phase
`timescale 1ns/1ps
module asc_counter (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [4:0] value,
  output logic            done
);

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;

  // ========================================================================
  // Count
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = value;
    end else if (cnt_ff != 5'h00) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done depends on the count alone, since load is itself computed from done
  assign done = (cnt_ff == 5'h01);

endmodule : asc_counter

/* File: tb/asc_sram_model.sv */
// Behavioural model of the 256K x 16 SRAM with error flag
`timescale 1ns/1ps
module asc_sram_model (
  input  wire asc_pkg::asc_pins_t pins,
  input  wire logic [15:0]        data_out,
  input  wire logic [15:0]        data_oe,
  input  wire logic               slow,
  input  wire logic [17:0]        bad_addr,
  output logic [15:0]             data_in,
  output logic                    err_in,
  output logic [7:0]              viol
);
  logic [15:0] mem [0:262143];
  logic [15:0] dq;
  logic        eq, sel, wr, rd_hi, rd_lo, w_hi, w_lo;
  logic        en_hi = 1'b0;
  logic        en_lo = 1'b0;
  int          wcnt = 0;
  realtime     td = 0.0, ta = 0.0, tw = 0.0;

  // ====================
  // Decode
  assign sel   = !pins.chip_select_low_n && pins.chip_select_high;
  assign wr    = sel && !pins.write_strobe_n &&
                 !(pins.upper_byte_select_n && pins.lower_byte_select_n);
  assign rd_hi = sel && pins.write_strobe_n && !pins.output_gate_n && !pins.upper_byte_select_n;
  assign rd_lo = sel && pins.write_strobe_n && !pins.output_gate_n && !pins.lower_byte_select_n;

  // ====================
  // Read path: one delay covers every access time, so old data holds meanwhile
  initial viol = 8'h00;
  always @(pins.addr or wcnt or bad_addr) begin
    dq <= #(slow ? 50 : 20) mem[pins.addr];
    eq <= #(slow ? 50 : 20) (pins.addr == bad_addr);
  end
  // Drive starts late, release is at once; a re-select inside the delay is not modelled
  always @(rd_hi) if (rd_hi) en_hi <= #(slow ? 50 : 20) 1'b1; else en_hi = 1'b0;
  always @(rd_lo) if (rd_lo) en_lo <= #(slow ? 50 : 20) 1'b1; else en_lo = 1'b0;
  // No pull on the bus: a floating lane shows the inverse of stored data
  assign data_in[15:8] = en_hi ? dq[15:8] : (data_oe[15] ? data_out[15:8] : ~dq[15:8]);
  assign data_in[7:0]  = en_lo ? dq[7:0] : (data_oe[0] ? data_out[7:0] : ~dq[7:0]);
  assign err_in        = (en_hi || en_lo) ? eq : ~eq;
  always @(en_hi or en_lo or data_oe) if ((en_hi || en_lo) && |data_oe) viol++;

  // ====================
  // Write path
  always @(data_out or data_oe) td = $realtime;
  always @(pins.addr) ta = $realtime;
  always @(negedge pins.write_strobe_n) tw = $realtime;
  always @* if (wr) begin
    w_hi = !pins.upper_byte_select_n;
    w_lo = !pins.lower_byte_select_n;
  end
  // Power-up takes wr from unknown to 0, which is no write end
  always @(negedge wr) if (tw > 0.0) begin
    if ($realtime - td < 25.0) viol++;
    if (ta > tw || $realtime - ta < 45.0) viol++;
    if ($realtime - tw < 45.0) viol++;
    if (w_hi) mem[pins.addr][15:8] = data_out[15:8];
    if (w_lo) mem[pins.addr][7:0] = data_out[7:0];
    wcnt++;
  end
endmodule : asc_sram_model

/* File: tb/tb_async_sram_ecc_access_timing.sv */
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module tb_async_sram_ecc_access_timing;
  logic               ref_clk, nrst, req_valid, req_ready, rsp_valid, rsp_err, err_in, slow;
  logic [15:0]        rsp_rdata, data_out, data_oe, data_in;
  logic [17:0]        bad_addr;
  logic [7:0]         viol;
  asc_pkg::asc_req_t  req;
  asc_pkg::asc_pins_t pins;
  int                 err_count, checks;

  asc_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .pins(pins), .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .err_in(err_in));
  asc_sram_model sram_u (.pins(pins), .data_out(data_out), .data_oe(data_oe), .slow(slow),
    .bad_addr(bad_addr), .data_in(data_in), .err_in(err_in), .viol(viol));

  // ====================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Counts falling edges from the take to the answer
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
                    input logic [1:0] be, output int lat, output logic hi);
    @(negedge ref_clk);
    while (req_ready !== 1'b1) @(negedge ref_clk);
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d, byte_en: be};
    @(negedge ref_clk);
    req_valid = 1'b0;
    lat = 1;
    hi = pins.write_strobe_n;
    while (rsp_valid !== 1'b1 && lat < 40) begin
      @(negedge ref_clk);
      lat++;
      hi = hi & pins.write_strobe_n;
    end
  endtask : op

  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    int   lat;
    logic hi;
    op(1'b1, a, d, be, lat, hi);
    chk("write latency", lat, (be == 2'b00) ? 15 : 13);
  endtask : wr

  task automatic rd(input logic [17:0] a, input logic [15:0] exp, input logic e);
    int   lat;
    logic hi;
    op(1'b0, a, 16'h0000, 2'b11, lat, hi);
    chk("read data", rsp_rdata, exp);
    chk("error flag", rsp_err, e);
    chk("read latency", lat, 15);
    chk("strobe in read", hi, 1'b1);
  endtask : rd

  // ====================
  // Scenarios
  task automatic t_reset;
    chk("deselect", {pins.chip_select_low_n, pins.chip_select_high}, 2'b10);
    chk("idle controls", {pins.write_strobe_n, pins.output_gate_n}, 2'b11);
    chk("idle drive", data_oe, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bytes;
    wr(18'h0000a, 16'h1234, 2'b11);
    wr(18'h0000a, 16'habcd, 2'b01);
    rd(18'h0000a, 16'h12cd, 1'b0);
    wr(18'h0000a, 16'h5678, 2'b10);
    wr(18'h0000a, 16'hffff, 2'b00);
    rd(18'h0000a, 16'h56cd, 1'b0);
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_err;
    @(negedge ref_clk);
    bad_addr = 18'h00020;
    wr(18'h00020, 16'h0f0f, 2'b11);
    rd(18'h00020, 16'h0f0f, 1'b1);
    rd(18'h0000a, 16'h56cd, 1'b0);
    $display("test error flag done");
  endtask : t_err

  task automatic t_slow;
    @(negedge ref_clk);
    slow = 1'b1;
    wr(18'h3ffff, 16'ha5a5, 2'b11);
    rd(18'h3ffff, 16'ha5a5, 1'b0);
    @(negedge ref_clk);
    slow = 1'b0;
    chk("host timing faults", viol, 8'h00);
    $display("test slow device done");
  endtask : t_slow

  // ====================
  // Clock, reset, run
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #20000;
    err_count++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    bad_addr = 18'h3fff0;
    err_count = 0;
    checks = 0;
    repeat (6) @(negedge ref_clk);
    t_reset();
    nrst = 1'b1;
    t_bytes();
    t_err();
    t_slow();
    stop_test();
  end
endmodule : tb_async_sram_ecc_access_timing
